// ===== rtl/nv_pkg.sv
// ============================================================================
// constants, register map and pin carrier for the nonvolatile sram host
// assumes a 40 MHz ref_clk and an external pull-up on the store-busy wire
// ============================================================================
package nv_pkg;
   // ========================================================================
   // clock and timing
   // ========================================================================
   localparam int CLK_MHZ     = 40;
   localparam int SYNC_DEPTH  = 2;
   localparam int ACCESS_NS   = 45;
   localparam int ACCESS_CYC  = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_CYC      = ACCESS_CYC + SYNC_DEPTH + 1;
   localparam int WR_PULSE_NS = 30;
   localparam int WR_CYC      = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int HW_PULSE_NS = 15;
   localparam int HW_CYC      = (HW_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int SS_US       = 70;
   localparam int SS_CYC      = SS_US * CLK_MHZ;
   localparam int DELAY_US    = 70;
   localparam int DELAY_CYC   = DELAY_US * CLK_MHZ;
   localparam int RECALL_US   = 100;
   localparam int RECALL_CYC  = RECALL_US * CLK_MHZ;
   localparam int STORE_MS    = 15;
   localparam int STORE_CYC   = STORE_MS * 1000 * CLK_MHZ;
   localparam int HRECALL_MS  = 20;
   localparam int HRECALL_CYC = HRECALL_MS * 1000 * CLK_MHZ;
   localparam int CNT_W       = 20;
   typedef logic [CNT_W-1:0] cnt_t;

   // ========================================================================
   // pins and command addresses
   // ========================================================================
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam logic [4:0][15:0] SEQ_PREFIX =
      {16'h703F, 16'h7C1F, 16'h83E0, 16'hB1C7, 16'h4E38};
   localparam logic [15:0] SEQ_STORE  = 16'h8FC0;
   localparam logic [15:0] SEQ_RECALL = 16'h4C63;
   localparam logic [15:0] SEQ_AS_DIS = 16'h8B45;
   localparam logic [15:0] SEQ_AS_EN  = 16'h8B46;

   typedef logic [2:0] op_t;
   localparam op_t OP_READ      = 3'h1;
   localparam op_t OP_WRITE     = 3'h2;
   localparam op_t OP_SW_STORE  = 3'h3;
   localparam op_t OP_SW_RECALL = 3'h4;
   localparam op_t OP_AS_DIS    = 3'h5;
   localparam op_t OP_AS_EN     = 3'h6;
   localparam op_t OP_HW_STORE  = 3'h7;

   // ========================================================================
   // register map
   // ========================================================================
   localparam logic [4:0] REG_CMD    = 5'h00;
   localparam logic [4:0] REG_ADDR   = 5'h04;
   localparam logic [4:0] REG_WDATA  = 5'h08;
   localparam logic [4:0] REG_RDATA  = 5'h0C;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam int ST_BUSY     = 0;
   localparam int ST_DEV_BUSY = 1;
   localparam int ST_REFUSED  = 2;
   localparam int ST_TIMEOUT  = 3;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 19'h00000;
   localparam logic [DATA_W-1:0] WDATA_RST = 8'h00;

   typedef struct packed {
      logic              chip_sel_n;
      logic              write_n;
      logic              out_gate_n;
      logic [ADDR_W-1:0] addr_pins;
      logic [DATA_W-1:0] data_pins_out;
      logic              data_pins_oe;
      logic              store_busy_pin_n_out;
      logic              store_busy_pin_n_oe;
   } pin_out_s;

   localparam pin_out_s PINS_IDLE = '{chip_sel_n: 1'b1, write_n: 1'b1,
      out_gate_n: 1'b1, addr_pins: ADDR_RST, data_pins_out: WDATA_RST,
      data_pins_oe: 1'b0, store_busy_pin_n_out: 1'b0,
      store_busy_pin_n_oe: 1'b0};
endpackage

// ===== rtl/nv_sram_host.sv
// ============================================================================
// host controller driving a nonvolatile-shadowed 512K x 8 sram over its pins
// assumes software on the plain register port and an external pull-up on
// the open-drain store-busy wire; the bench resolves the two-way pins
// ============================================================================
`timescale 1ns/1ps
module nv_sram_host #(
   parameter int unsigned STORE_CYCLES   = nv_pkg::STORE_CYC,
   parameter int unsigned RESTORE_CYCLES = nv_pkg::HRECALL_CYC
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   input  wire logic [4:0]                 bus_addr,
   input  wire logic [31:0]                bus_wdata,
   input  wire logic                       bus_wr,
   input  wire logic                       bus_rd,
   output logic      [31:0]                bus_rdata,
   output nv_pkg::pin_out_s                pins,
   input  wire logic [nv_pkg::DATA_W-1:0]  data_pins_in,
   input  wire logic                       store_busy_pin_n_in
);
   typedef enum logic [2:0] {
      S_PWRUP, S_IDLE, S_SETUP, S_STROBE, S_END, S_HWPULSE, S_WAIT, S_HOLD
   } state_e;

   state_e                     state;
   state_e                     next_state;
   logic [2:0]                 step;
   logic [2:0]                 next_step;
   nv_pkg::cnt_t               cnt;
   nv_pkg::cnt_t               next_cnt;
   nv_pkg::pin_out_s           next_pins;
   logic                       go;
   nv_pkg::op_t                op;
   logic [nv_pkg::ADDR_W-1:0]  addr_reg;
   logic [nv_pkg::DATA_W-1:0]  wdata_reg;
   logic [nv_pkg::DATA_W-1:0]  rdata_reg;
   logic [nv_pkg::DATA_W-1:0]  data_s;
   logic                       busy_s;
   logic                       refused;
   logic                       timed_out;
   logic                       is_cmd;
   logic                       host_busy;
   logic                       cmd_ok;

   // ========================================================================
   // pin synchronisers
   // ========================================================================
   pin_sync #(.W(nv_pkg::DATA_W), .RST_VAL(8'h00)) data_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       (data_pins_in),
      .q       (data_s)
   );

   pin_sync #(.W(1), .RST_VAL(1'b1)) busy_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       (store_busy_pin_n_in),
      .q       (busy_s)
   );

   // ========================================================================
   // address of each bus cycle
   // ========================================================================
   function automatic logic [nv_pkg::ADDR_W-1:0] seq_addr(
      input nv_pkg::op_t                o,
      input logic [2:0]                 s,
      input logic [nv_pkg::ADDR_W-1:0]  a);
      logic [15:0] low;
      low = nv_pkg::SEQ_STORE;
      if (o == nv_pkg::OP_READ || o == nv_pkg::OP_WRITE) begin
         return a;
      end
      if (s < 3'h5) begin
         low = nv_pkg::SEQ_PREFIX[s];
      end else if (o == nv_pkg::OP_SW_RECALL) begin
         low = nv_pkg::SEQ_RECALL;
      end else if (o == nv_pkg::OP_AS_DIS) begin
         low = nv_pkg::SEQ_AS_DIS;
      end else if (o == nv_pkg::OP_AS_EN) begin
         low = nv_pkg::SEQ_AS_EN;
      end
      return {3'h0, low};
   endfunction

   assign is_cmd = op inside {nv_pkg::OP_SW_STORE, nv_pkg::OP_SW_RECALL,
                              nv_pkg::OP_AS_DIS, nv_pkg::OP_AS_EN};
   assign host_busy = (state != S_IDLE) || go;
   // new work only while the host is idle and store-busy is released
   assign cmd_ok = !host_busy && busy_s && (bus_wdata[2:0] != 3'h0);

   // ========================================================================
   // sequencer
   // ========================================================================
   always_comb begin
      next_state = state;
      next_step  = step;
      next_cnt   = cnt;
      next_pins  = pins;
      unique case (state)
         S_PWRUP: begin
            // wait out the power-up recall with the chip deselected
            if (cnt == '0) next_state = S_IDLE;
            else next_cnt = cnt - 1'b1;
         end
         S_IDLE: begin
            if (go && op == nv_pkg::OP_HW_STORE) begin
               next_state = S_HWPULSE;
               next_pins.store_busy_pin_n_oe = 1'b1;
               next_cnt = nv_pkg::cnt_t'(nv_pkg::HW_CYC - 1);
            end else if (go) begin
               next_state = S_SETUP;
               next_step  = 3'h0;
               next_pins.addr_pins = seq_addr(op, 3'h0, addr_reg);
            end
         end
         S_SETUP: begin
            next_state = S_STROBE;
            next_pins.chip_sel_n = 1'b0;
            if (op == nv_pkg::OP_WRITE) begin
               next_pins.write_n       = 1'b0;
               next_pins.data_pins_out = wdata_reg;
               next_pins.data_pins_oe  = 1'b1;
               next_cnt = nv_pkg::cnt_t'(nv_pkg::WR_CYC - 1);
            end else begin
               next_pins.out_gate_n = 1'b0;
               next_cnt = nv_pkg::cnt_t'(nv_pkg::RD_CYC - 1);
            end
         end
         S_STROBE: begin
            if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else begin
               next_state = S_END;
               next_pins.chip_sel_n = 1'b1;
               next_pins.write_n    = 1'b1;
               next_pins.out_gate_n = 1'b1;
            end
         end
         S_END: begin
            next_pins.data_pins_oe = 1'b0;
            if (is_cmd && step < 3'h5) begin
               // address moves only while select is high
               next_step  = step + 3'h1;
               next_state = S_SETUP;
               next_pins.addr_pins = seq_addr(op, step + 3'h1, addr_reg);
            end else if (is_cmd) begin
               next_state = S_WAIT;
               next_cnt = (op == nv_pkg::OP_SW_RECALL)
                  ? nv_pkg::cnt_t'(nv_pkg::RECALL_CYC - 1)
                  : nv_pkg::cnt_t'(nv_pkg::SS_CYC - 1);
            end else begin
               next_state = S_IDLE;
            end
         end
         S_HWPULSE: begin
            if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else begin
               next_state = S_WAIT;
               next_pins.store_busy_pin_n_oe = 1'b0;
               next_cnt = nv_pkg::cnt_t'(nv_pkg::DELAY_CYC - 1);
            end
         end
         S_WAIT: begin
            // a skipped store leaves store-busy high and ends here
            if (cnt != '0) next_cnt = cnt - 1'b1;
            else if (busy_s) next_state = S_IDLE;
            else begin
               next_state = S_HOLD;
               next_cnt = nv_pkg::cnt_t'(STORE_CYCLES - 1);
            end
         end
         S_HOLD: begin
            if (busy_s || cnt == '0) next_state = S_IDLE;
            else next_cnt = cnt - 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= S_PWRUP;
         step  <= 3'h0;
         cnt   <= nv_pkg::cnt_t'(RESTORE_CYCLES - 1);
         pins  <= nv_pkg::PINS_IDLE;
      end else begin
         state <= next_state;
         step  <= next_step;
         cnt   <= next_cnt;
         pins  <= next_pins;
      end
   end

   // ========================================================================
   // register port
   // ========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         go        <= 1'b0;
         op        <= nv_pkg::OP_READ;
         addr_reg  <= nv_pkg::ADDR_RST;
         wdata_reg <= nv_pkg::WDATA_RST;
         refused   <= 1'b0;
         timed_out <= 1'b0;
      end else begin
         go <= 1'b0;
         if (bus_wr && bus_addr == nv_pkg::REG_STATUS) begin
            if (bus_wdata[nv_pkg::ST_REFUSED]) refused <= 1'b0;
            if (bus_wdata[nv_pkg::ST_TIMEOUT]) timed_out <= 1'b0;
         end
         if (bus_wr && bus_addr == nv_pkg::REG_ADDR && !host_busy)
            addr_reg <= bus_wdata[nv_pkg::ADDR_W-1:0];
         if (bus_wr && bus_addr == nv_pkg::REG_WDATA && !host_busy)
            wdata_reg <= bus_wdata[nv_pkg::DATA_W-1:0];
         if (bus_wr && bus_addr == nv_pkg::REG_CMD) begin
            if (cmd_ok) begin
               go <= 1'b1;
               op <= bus_wdata[2:0];
            end else begin
               refused <= 1'b1;
            end
         end
         if (state == S_HOLD && !busy_s && cnt == '0) timed_out <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= nv_pkg::WDATA_RST;
      end else if (state == S_STROBE && cnt == '0
                   && op == nv_pkg::OP_READ) begin
         rdata_reg <= data_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_rdata <= 32'h0;
      end else begin
         bus_rdata <= 32'h0;
         if (bus_rd) begin
            unique case (bus_addr)
               nv_pkg::REG_CMD:    bus_rdata <= {29'h0, op};
               nv_pkg::REG_ADDR:   bus_rdata <= {13'h0, addr_reg};
               nv_pkg::REG_WDATA:  bus_rdata <= {24'h0, wdata_reg};
               nv_pkg::REG_RDATA:  bus_rdata <= {24'h0, rdata_reg};
               nv_pkg::REG_STATUS: bus_rdata <= {28'h0, timed_out, refused,
                                                 !busy_s, host_busy};
               default:            bus_rdata <= 32'h0;
            endcase
         end
      end
   end

   // ========================================================================
   // assertions
   // ========================================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_read_pins;
      !pins.out_gate_n |-> !pins.chip_sel_n && pins.write_n
                           && !pins.data_pins_oe;
   endproperty
   a_read_pins: assert property (p_read_pins)
      else $error("read strobe with wrong pin levels");

   property p_addr_steady;
      !pins.chip_sel_n && $past(!pins.chip_sel_n) |-> $stable(pins.addr_pins);
   endproperty
   a_addr_steady: assert property (p_addr_steady)
      else $error("address moved while selected");

   property p_write_gate;
      !pins.write_n || pins.data_pins_oe |-> pins.out_gate_n;
   endproperty
   a_write_gate: assert property (p_write_gate)
      else $error("output gate low during a write");

   property p_write_len;
      $fell(pins.write_n) |-> (!pins.write_n && !pins.chip_sel_n)[*2]
                              ##1 (pins.write_n && pins.chip_sel_n);
   endproperty
   a_write_len: assert property (p_write_len)
      else $error("write strobe length wrong");

   property p_cmd_prefix;
      $fell(pins.chip_sel_n) && is_cmd && step < 3'h5
         |-> pins.addr_pins == {3'h0, nv_pkg::SEQ_PREFIX[step]};
   endproperty
   a_cmd_prefix: assert property (p_cmd_prefix)
      else $error("command prefix address out of order");

   property p_cmd_no_write;
      is_cmd && state inside {S_SETUP, S_STROBE, S_END}
         |-> pins.write_n && pins.addr_pins[18:16] == 3'h0;
   endproperty
   a_cmd_no_write: assert property (p_cmd_no_write)
      else $error("command read with write strobe or high address");

   property p_start_idle_dev;
      $fell(pins.chip_sel_n) && step == 3'h0 |-> $past(busy_s, 3);
   endproperty
   a_start_idle_dev: assert property (p_start_idle_dev)
      else $error("access began while store-busy was low");

   property p_hw_pulse;
      $rose(pins.store_busy_pin_n_oe) |-> pins.chip_sel_n
         ##1 !pins.store_busy_pin_n_oe ##1 state == S_WAIT;
   endproperty
   a_hw_pulse: assert property (p_hw_pulse)
      else $error("store request pulse malformed");

   property p_powerup;
      state == S_PWRUP |-> pins.chip_sel_n && pins.write_n && host_busy;
   endproperty
   a_powerup: assert property (p_powerup)
      else $error("pins active during power-up recall");

   property p_idle_float;
      // write data stays one cycle past select for hold time
      pins.chip_sel_n |-> pins.out_gate_n
         && (!pins.data_pins_oe || state == S_END);
   endproperty
   a_idle_float: assert property (p_idle_float)
      else $error("data driven while deselected");

   c_read:   cover property (state == S_END && op == nv_pkg::OP_READ);
   c_write:  cover property (state == S_END && op == nv_pkg::OP_WRITE);
   c_sw_cmd: cover property (state == S_WAIT && is_cmd);
   c_hw_hold: cover property (state == S_HOLD && busy_s);
endmodule

// ===== rtl/pin_sync.sv
// ============================================================================
// two-flop synchroniser for pins that arrive from outside ref_clk
// assumes a synchronous active-high reset
// ============================================================================
`timescale 1ns/1ps
module pin_sync #(
   parameter int            W       = 1,
   parameter logic [W-1:0]  RST_VAL = '0
) (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);
   logic [W-1:0] meta;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ===== tb/nv_dev_model.sv
// behavioural nonvolatile sram standing behind the host's pins
// assumes the bench resolves the data wire and the pulled-up store-busy wire
`timescale 1ns/1ps
module nv_dev_model (
   input  wire nv_pkg::pin_out_s pins,
   input  wire logic [7:0]       data_wire,
   input  wire logic             busy_wire,
   input  wire logic             supply_ok,
   output logic      [7:0]       dev_data,
   output logic                  dev_oe,
   output logic                  dev_pull,
   output logic      [23:0]      state
);
   localparam logic [15:0] PFX [5] =
      '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
   logic [7:0] mem [0:524287];
   logic       lock = 1'b1;
   logic       dirty = 1'b0;
   logic [7:0] n_store = 8'h00;
   logic [7:0] n_recall = 8'h01;
   logic       as_en = 1'b1;
   logic       armed = 1'b0;
   int         step = 0;
   initial dev_pull = 1'b0;
   assign state = {n_store, n_recall, 7'h00, as_en};
   assign dev_oe = !pins.chip_sel_n && !pins.out_gate_n && pins.write_n
      && busy_wire && !lock;
   assign dev_data = mem[pins.addr_pins];
   // power-up recall keeps the array shut for a short while
   initial #375 lock = 1'b0;
   // a write only lands if it began while the array was open
   always @(negedge (pins.chip_sel_n | pins.write_n))
      armed = busy_wire && !lock;
   always @(posedge (pins.chip_sel_n | pins.write_n))
      if (armed && busy_wire && !lock) begin
         mem[pins.addr_pins] = data_wire;
         dirty = 1'b1;
      end
   task automatic run(input logic st, input logic hw);
      if (hw) #(1600 * 25);
      if (!hw || dirty) begin
         lock = 1'b1;
         dev_pull = st;
         dirty = 1'b0;
         if (st) n_store++;
         else n_recall++;
         #((st ? (hw ? 1230 : 2830) : 3900) * 25);
         lock = 1'b0;
         dev_pull = 1'b0;
      end
   endtask
   always @(negedge busy_wire)
      if (!dev_pull && !lock) fork run(1'b1, 1'b1); join_none
   // supply loss shuts the array, stores if enabled and dirty, recalls on return
   always @(negedge supply_ok) begin
      lock = 1'b1;
      if (as_en && dirty) begin
         dev_pull = 1'b1;
         dirty = 1'b0;
         n_store++;
         #(200 * 25);
         dev_pull = 1'b0;
      end
      wait (supply_ok);
      run(1'b0, 1'b0);
   end
   always @(negedge (pins.chip_sel_n | pins.out_gate_n)) begin
      if (!pins.write_n || lock) step = 0;
      else if (step < 5)
         step = (pins.addr_pins[15:0] == PFX[step]) ? step + 1 : 0;
      else begin
         step = 0;
         case (pins.addr_pins[15:0])
            16'h8FC0: fork run(1'b1, 1'b0); join_none
            16'h4C63: fork run(1'b0, 1'b0); join_none
            16'h8B45: as_en = 1'b0;
            16'h8B46: as_en = 1'b1;
            default: ;
         endcase
      end
   end
endmodule

// ===== tb/tb.sv
// self-checking bench for the host controller and its device model
// assumes the small count parameters set below
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [31:0] exp;
      logic [31:0] mask;
   } note_s;
   localparam nv_pkg::op_t OPS [6] = '{nv_pkg::OP_HW_STORE,
      nv_pkg::OP_HW_STORE, nv_pkg::OP_SW_STORE, nv_pkg::OP_AS_DIS,
      nv_pkg::OP_AS_EN, nv_pkg::OP_SW_RECALL};
   localparam logic [23:0] ST [6] = '{24'h010101, 24'h010101, 24'h020101,
      24'h020100, 24'h020101, 24'h020201};
   logic             ref_clk = 1'b0;
   logic             rst = 1'b1;
   logic [4:0]       bus_addr = 5'h00;
   logic [31:0]      bus_wdata = 32'h0;
   logic             bus_wr = 1'b0;
   logic             bus_rd = 1'b0;
   logic             rd_seen = 1'b0;
   logic [31:0]      bus_rdata;
   nv_pkg::pin_out_s pins;
   logic [7:0]       dev_data;
   logic [7:0]       churn = 8'h00;
   logic             dev_oe;
   logic             supply_ok = 1'b1;
   logic             dev_pull;
   logic [23:0]      state;
   wire logic [7:0]  data_wire;
   wire logic        busy_wire;
   note_s            note_q [$];
   int               n_mismatch = 0;
   int               comparisons = 0;
   logic [18:0]      a [4];
   logic [7:0]       d [4];
   // ==========================================================
   // clock, wires and instances
   // ==========================================================
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) churn <= churn + 8'h35;
   // an undriven data wire shows a pattern that moves every cycle
   assign data_wire = pins.data_pins_oe ? pins.data_pins_out :
      dev_oe ? dev_data : churn;
   assign busy_wire = !(pins.store_busy_pin_n_oe &&
      !pins.store_busy_pin_n_out) && !dev_pull;
   nv_sram_host #(.STORE_CYCLES(50), .RESTORE_CYCLES(20)) nv_sram_host_i (
      .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .pins(pins), .data_pins_in(data_wire),
      .store_busy_pin_n_in(busy_wire));
   nv_dev_model nv_dev_model_i (.pins(pins), .data_wire(data_wire),
      .busy_wire(busy_wire), .supply_ok(supply_ok), .dev_data(dev_data),
      .dev_oe(dev_oe), .dev_pull(dev_pull), .state(state));
   // ==========================================================
   // tasks
   // ==========================================================
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [4:0] adr, input logic [31:0] val);
      @(posedge ref_clk);
      bus_addr <= adr;
      bus_wdata <= val;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [4:0] adr, input logic [31:0] exp,
                         input logic [31:0] mask);
      @(posedge ref_clk);
      bus_addr <= adr;
      bus_rd <= 1'b1;
      note_q.push_back({exp, mask});
      @(posedge ref_clk);
      bus_rd <= 1'b0;
   endtask
   task automatic cmd(input nv_pkg::op_t op);
      reg_wr(nv_pkg::REG_CMD, 32'(op));
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 4000; i++) begin
         reg_rd(nv_pkg::REG_STATUS, 32'h0, 32'h0);
         @(negedge ref_clk);
         if (bus_rdata[nv_pkg::ST_BUSY] === 1'b0) return;
      end
      n_mismatch++;
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // watcher, watchdog and tests
   // ==========================================================
   always @(posedge ref_clk) rd_seen <= bus_rd;
   always @(negedge ref_clk) begin
      note_s n;
      if (rd_seen) begin
         n = note_q.pop_front();
         if (n.mask !== 32'h0)
            check("bus_rdata", bus_rdata & n.mask, n.exp & n.mask);
      end
   end
   initial begin
      #(60000 * 25);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      void'($urandom(1775));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      cmd(nv_pkg::OP_READ);
      reg_rd(nv_pkg::REG_STATUS, 32'h4, 32'h4);
      wait_idle();
      reg_wr(nv_pkg::REG_STATUS, 32'hC);
      reg_rd(nv_pkg::REG_STATUS, 32'h0, 32'hF);
      reg_rd(5'h14, 32'h0, 32'hFFFFFFFF);
      for (int i = 0; i < 8; i++) begin
         if (i < 4) begin
            a[i] = (i == 3) ? a[0] ^ 19'h40000 : 19'($urandom());
            d[i] = (i == 3) ? ~d[0] : 8'($urandom());
            reg_wr(nv_pkg::REG_WDATA, {24'h0, d[i]});
         end
         reg_wr(nv_pkg::REG_ADDR, {13'h0, a[i % 4]});
         cmd(i < 4 ? nv_pkg::OP_WRITE : nv_pkg::OP_READ);
         wait_idle();
         if (i > 3)
            reg_rd(nv_pkg::REG_RDATA, {24'h0, d[i % 4]}, 32'hFF);
      end
      for (int k = 0; k < 6; k++) begin
         cmd(OPS[k]);
         if (k == 2) begin
            cmd(nv_pkg::OP_READ);
            repeat (100) @(posedge ref_clk);
            reg_rd(nv_pkg::REG_STATUS, 32'h7, 32'h7);
         end
         wait_idle();
         check("dev_state", {8'h0, state}, {8'h0, ST[k]});
      end
      cmd(nv_pkg::OP_WRITE);
      wait_idle();
      supply_ok <= 1'b0;
      repeat (50) @(posedge ref_clk);
      reg_rd(nv_pkg::REG_STATUS, 32'h6, 32'hF);
      repeat (300) @(posedge ref_clk);
      supply_ok <= 1'b1;
      repeat (4000) @(posedge ref_clk);
      check("dev_state", {8'h0, state}, 32'h00030301);
      reg_rd(nv_pkg::REG_STATUS, 32'h4, 32'hF);
      repeat (4) @(posedge ref_clk);
      print_verdict();
   end
endmodule
